/* hw/rstc_consts.vh */
// Constants for the reversible shifter and table comparator block
`ifndef RSTC_CONSTS_VH
`define RSTC_CONSTS_VH
`define RSTC_CTL_DIR_BIT     12
`define RSTC_CTL_SIN_BIT     13
`define RSTC_CTL_EN_BIT      14
`define RSTC_CTL_CLR_BIT     15
`define RSTC_TABLE_WORDS     16
`define RSTC_TABLE_AW        4
`define RSTC_WORD_RESET      16'h0000
`define RSTC_CARRY_RESET     1'b0
`define RSTC_ADR_CTRL        8'h00
`define RSTC_ADR_FIRST       8'h04
`define RSTC_ADR_LAST        8'h08
`define RSTC_ADR_CMD         8'h0c
`define RSTC_ADR_STATUS      8'h10
`define RSTC_ADR_CVAL        8'h14
`define RSTC_ADR_RESULT      8'h18
`define RSTC_ADR_CHAIN_BASE  8'h40
`define RSTC_ADR_TABLE_BASE  8'h80
`define RSTC_CMD_SHIFT_BIT   0
`define RSTC_CMD_CMP_BIT     1
`define RSTC_CMD_COND_BIT    2
`endif

/* hw/rstc_word_mem.v */
// Word memory with registered read data, used for table storage
`timescale 1ns/10ps
module rstc_word_mem #(
   parameter DW = 16,
   parameter AW = 4
) (
   input  wire          clk_i,
   input  wire          we_i,
   input  wire [AW-1:0] waddr_i,
   input  wire [DW-1:0] wdata_i,
   input  wire [AW-1:0] raddr_i,
   output reg  [DW-1:0] rdata_o
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // Write port and registered read port
   always @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule

/* hw/rstc_top.v */
// Reversible multi-word shifter and 16-word table comparator, Wishbone slave
//
// Overview of operation
// - Words first through last form one bit chain, moved one place per enabled run.
// - Control bit 12 zero shifts right, one shifts left.
// - Control bit 13 enters the vacated end; the bit pushed out goes to carry.
// - Control bit 14 zero leaves chain and carry unchanged except by a clear (bit 15).
// - Control bit 15 with true input condition clears all chain words and carry.
// - Compare value is matched against each of 16 consecutive table words.
// - Result bit is one on agreement, zero otherwise.
`timescale 1ns/10ps
`include "rstc_consts.vh"
module rstc_top #(
   parameter CHAIN_AW = 4
) (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output wire        ack_o,
   output wire        busy_o,
   output wire        carry_flag_o
);
   localparam NW = (1 << CHAIN_AW);
   // One-hot engine states
   localparam [3:0] S_IDLE = 4'b0001;
   localparam [3:0] S_SHIFT = 4'b0010;
   localparam [3:0] S_CLEAR = 4'b0100;
   localparam [3:0] S_CMP  = 4'b1000;
   localparam [4:0] TBL_END = `RSTC_TABLE_WORDS;

   reg [15:0]         ctrl_reg;
   reg [CHAIN_AW-1:0] first_word_reg;
   reg [CHAIN_AW-1:0] last_word_reg;
   reg [15:0]         compare_value_reg;
   reg [15:0]         result_reg;
   reg                carry_flag_reg;
   reg [3:0]          state_reg;
   reg [CHAIN_AW-1:0] idx_reg;
   reg [3:0]          state_next;
   reg                inbit_reg;
   reg [4:0]          tidx_reg;
   reg                ack_reg;
   // All chain words side by side, 16 bits per word
   wire [16*NW-1:0]   chain_flat;

   // Bus decode; a request counts once, while ack is still low
   wire bus_req = cyc_i & stb_i & ~ack_reg;
   wire wr_req  = bus_req & we_i & sel_i[0] & sel_i[1];
   wire idle    = state_reg == S_IDLE;
   wire dir_left = ctrl_reg[`RSTC_CTL_DIR_BIT];

   assign ack_o        = ack_reg;
   assign busy_o       = ~idle;
   assign carry_flag_o = carry_flag_reg;

   // Table write decode; table writes go to the memory module
   wire tbl_hit = adr_i[7:6] == 2'b10;
   wire tbl_we  = wr_req & tbl_hit & idle;
   wire [15:0] tbl_q;
   // Table is write-only on the bus, so the compare walk owns the read port
   wire [3:0]  tbl_raddr = tidx_reg[3:0];

   rstc_word_mem #(
      .DW      (16),
      .AW      (`RSTC_TABLE_AW)
   ) u_table (
      .clk_i   (clk_i),
      .we_i    (tbl_we),
      .waddr_i (adr_i[5:2]),
      .wdata_i (dat_i[15:0]),
      .raddr_i (tbl_raddr),
      .rdata_o (tbl_q)
   );

   // Chain index and next word position when walking
   wire [CHAIN_AW-1:0] end_idx = dir_left ? first_word_reg : last_word_reg;
   wire [CHAIN_AW-1:0] stop_idx = dir_left ? last_word_reg : first_word_reg;
   wire [15:0]         cw = chain_flat[16*idx_reg +: 16];
   // Left walks first to last, bit 15 into the next word's bit 0; right walks back
   wire [15:0] shifted = dir_left ? {cw[14:0], inbit_reg} : {inbit_reg, cw[15:1]};
   wire        outbit  = dir_left ? cw[15] : cw[0];
   wire        chain_hit = adr_i[7:6] == 2'b01;
   wire [CHAIN_AW-1:0] chain_idx = adr_i[CHAIN_AW+1:2];

   // Bus ack: one wait-free cycle, dropped the cycle after
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= bus_req;
      end
   end

   // Registered read data mux
   always @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (bus_req & ~we_i) begin
         case (adr_i)
            `RSTC_ADR_CTRL:   dat_o <= {16'h0000, ctrl_reg};
            `RSTC_ADR_FIRST:  dat_o <= {{(32-CHAIN_AW){1'b0}}, first_word_reg};
            `RSTC_ADR_LAST:   dat_o <= {{(32-CHAIN_AW){1'b0}}, last_word_reg};
            `RSTC_ADR_STATUS: dat_o <= {30'h0, busy_o, carry_flag_reg};
            `RSTC_ADR_CVAL:   dat_o <= {16'h0000, compare_value_reg};
            `RSTC_ADR_RESULT: dat_o <= {16'h0000, result_reg};
            default: begin
               if (chain_hit) begin
                  dat_o <= {16'h0000, chain_flat[16*chain_idx +: 16]};
               end else begin
                  dat_o <= 32'h0000_0000;
               end
            end
         endcase
      end
   end

   // Software-written configuration registers
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg          <= 16'h0000;
         first_word_reg    <= {CHAIN_AW{1'b0}};
         last_word_reg     <= {CHAIN_AW{1'b0}};
         compare_value_reg <= 16'h0000;
      end else if (wr_req & idle) begin
         case (adr_i)
            `RSTC_ADR_CTRL:  ctrl_reg          <= dat_i[15:0];
            `RSTC_ADR_FIRST: first_word_reg    <= dat_i[CHAIN_AW-1:0];
            `RSTC_ADR_LAST:  last_word_reg     <= dat_i[CHAIN_AW-1:0];
            `RSTC_ADR_CVAL:  compare_value_reg <= dat_i[15:0];
            default: ;
         endcase
      end
   end

   // Command decode
   wire cmd_wr   = wr_req & idle & (adr_i == `RSTC_ADR_CMD);
   wire do_shift = cmd_wr & dat_i[`RSTC_CMD_SHIFT_BIT];
   wire do_cmp   = cmd_wr & dat_i[`RSTC_CMD_CMP_BIT];
   wire cond     = dat_i[`RSTC_CMD_COND_BIT];
   wire clr_req  = ctrl_reg[`RSTC_CTL_CLR_BIT] & cond;
   wire en_req   = ctrl_reg[`RSTC_CTL_EN_BIT];

   // Limits: one command at a time; writes while busy are acked but dropped,
   // so software polls busy first. A first word above the last is not
   // caught here: the walk then wraps round the word index.

   // Engine phase and start decode; starts are idle-only via the command decode
   wire shifting    = state_reg == S_SHIFT;
   wire clearing    = state_reg == S_CLEAR;
   wire comparing   = state_reg == S_CMP;
   wire start_clr   = do_shift & clr_req;
   wire start_shift = do_shift & ~clr_req & en_req;
   wire start_cmp   = do_cmp & ~start_clr & ~start_shift;

   // End points and the per-entry match
   wire walk_done   = idx_reg == stop_idx;
   wire cmp_done    = tidx_reg == TBL_END;
   wire tbl_match   = tbl_q == compare_value_reg;
   wire chain_wr    = wr_req & chain_hit & idle;

   // Next engine state; a shift walks last-first+1 words, a compare takes
   // one cycle per entry plus one for the memory's registered read
   always @* begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE: begin
            // Clear outranks shift, shift outranks compare
            if (start_clr) begin
               state_next = S_CLEAR;
            end else if (start_shift) begin
               state_next = S_SHIFT;
            end else if (start_cmp) begin
               state_next = S_CMP;
            end
         end
         S_CLEAR: begin
            state_next = S_IDLE;
         end
         S_SHIFT: begin
            if (walk_done) begin
               state_next = S_IDLE;
            end
         end
         S_CMP: begin
            // Index 16 collects the late read of entry 15
            if (cmp_done) begin
               state_next = S_IDLE;
            end
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   // Engine state register
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= S_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Walk position: starts at the entry end, steps toward the far end;
   // it stops on the far word so a stale index never wraps
   always @(posedge clk_i) begin
      if (rst_i) begin
         idx_reg <= {CHAIN_AW{1'b0}};
      end else if (start_shift) begin
         idx_reg <= end_idx;
      end else if (shifting & ~walk_done) begin
         if (dir_left) begin
            idx_reg <= idx_reg + 1'b1;
         end else begin
            idx_reg <= idx_reg - 1'b1;
         end
      end
   end

   // Bit handed from one word to the next; serial input for the entry word
   always @(posedge clk_i) begin
      if (rst_i) begin
         inbit_reg <= 1'b0;
      end else if (start_shift) begin
         inbit_reg <= ctrl_reg[`RSTC_CTL_SIN_BIT];
      end else if (shifting) begin
         inbit_reg <= outbit;
      end
   end

   // Carry: bit pushed out of the far word, zeroed by a clear;
   // a disabled shift never reaches here, so carry holds
   always @(posedge clk_i) begin
      if (rst_i) begin
         carry_flag_reg <= `RSTC_CARRY_RESET;
      end else if (clearing) begin
         carry_flag_reg <= 1'b0;
      end else if (shifting & walk_done) begin
         carry_flag_reg <= outbit;
      end
   end

   // Table index; runs one past the last entry to collect its late read,
   // then rests at 16, whose low bits point at entry 0 for the next start
   always @(posedge clk_i) begin
      if (rst_i) begin
         tidx_reg <= 5'h00;
      end else if (start_cmp) begin
         tidx_reg <= 5'h00;
      end else if (comparing & ~cmp_done) begin
         tidx_reg <= tidx_reg + 5'h01;
      end
   end

   // Result bits: the memory answers one cycle after the index, so entry k
   // lands on bit k while the index reads k+1
   always @(posedge clk_i) begin
      if (rst_i) begin
         result_reg <= 16'h0000;
      end else if (comparing & (tidx_reg != 5'h00)) begin
         result_reg[tidx_reg[3:0] - 4'h1] <= tbl_match;
      end
   end

   // Chain words live in flops, not the memory module: a clear must zero the
   // whole range in one cycle, which a single-port memory cannot do.
   // Words outside first..last are not part of the chain and keep their value.
   genvar g;
   generate
      for (g = 0; g < NW; g = g + 1) begin : g_chain
         reg  [15:0] word_reg;
         wire        in_range;
         wire        shift_load;
         wire        bus_load;
         assign in_range   = (g >= first_word_reg) && (g <= last_word_reg);
         assign shift_load = shifting & (idx_reg == g);
         assign bus_load   = chain_wr & (chain_idx == g);
         // Clear first, then the shift walk, then software loads
         always @(posedge clk_i) begin
            if (rst_i) begin
               word_reg <= `RSTC_WORD_RESET;
            end else if (clearing & in_range) begin
               word_reg <= `RSTC_WORD_RESET;
            end else if (shift_load) begin
               word_reg <= shifted;
            end else if (bus_load) begin
               word_reg <= dat_i[15:0];
            end
         end
         assign chain_flat[16*g +: 16] = word_reg;
      end
   endgenerate
endmodule

/* sim/rstc_top_checker.sv */
// Port-level assertions for the shifter and table comparator
`timescale 1ns/10ps
module rstc_top_checker #(
   parameter CHAIN_AW = 4
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        busy_o,
   input wire logic        carry_flag_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [5:0] busy_run;
   // Busy length; compare is the longest run at 17 cycles
   always @(posedge clk_i) begin
      busy_run <= (rst_i || !busy_o) ? 6'h00 : busy_run + 6'h01;
   end
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
   ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
   ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("stray ack");
   read_hold_a: assert property (!$stable(dat_o) |-> ack_o && $past(!we_i)) else $error("dat_o moved");
   unmapped_zero_a: assert property (ack_o && $past(!we_i && adr_i == 8'h20) |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   carry_quiet_a: assert property (!$stable(carry_flag_o) |-> $past(busy_o) || $past(busy_o, 2))
      else $error("carry moved while idle");
   reset_clean_a: assert property ($fell(rst_i) |-> !busy_o && !carry_flag_o && !ack_o)
      else $error("state after reset");
   busy_bound_a: assert property (busy_run <= 6'd17) else $error("busy too long");
   cover property ($rose(busy_o));
   cover property ($rose(carry_flag_o));
   cover property (ack_o && $past(!we_i));
endmodule
bind rstc_top rstc_top_checker #(.CHAIN_AW(CHAIN_AW)) chk (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .dat_o(dat_o), .ack_o(ack_o), .busy_o(busy_o), .carry_flag_o(carry_flag_o));

/* sim/rstc_seq_model.sv */
// Sequencer model issuing classic Wishbone cycles
`timescale 1ns/10ps
module rstc_seq_model (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] rdat_i,
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [7:0]       adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      dat_o
);
   initial begin
      {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
   end
   // Request held until ack is sampled high
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'hf, d};
      do @(posedge clk_i); while (ack_i !== 1'b1);
      q = rdat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      dat_o <= ~d; // Released data must not look valid
   endtask
endmodule

/* sim/rstc_top_bench.sv */
// Self-checking bench for the shifter and table comparator
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
   $display("ERROR %0t got %h want %h", $time, a, b); end end
module rstc_top_bench;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i, stb_i, we_i, ack_o, busy_o, carry_flag_o;
   logic [7:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o, rd;
   int          fails = 0;
   int          checks_done = 0;
   always #10 clk_i = ~clk_i;
   rstc_top #(.CHAIN_AW(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .busy_o(busy_o), .carry_flag_o(carry_flag_o));
   rstc_seq_model seq (.clk_i(clk_i), .ack_i(ack_o), .rdat_i(dat_o), .cyc_o(cyc_i),
      .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
   task wr(input logic [7:0] a, input logic [31:0] d);
      seq.xfer(1'b1, a, d, rd);
   endtask
   task chk_rd(input logic [7:0] a, input logic [31:0] e);
      seq.xfer(1'b0, a, 32'h0, rd);
      `CHK(rd, e)
   endtask
   // Start a command and poll busy with a bounded count
   task cmd(input logic [31:0] c);
      int n;
      n = 0;
      wr(8'h0c, c);
      seq.xfer(1'b0, 8'h10, 32'h0, rd);
      while (rd[1] && n < 60) begin
         seq.xfer(1'b0, 8'h10, 32'h0, rd);
         n++;
      end
      if (rd[1]) begin
         fails++;
         $display("ERROR %0t engine still busy", $time);
      end
   endtask
   task t_shift;
      chk_rd(8'h20, 32'h0);
      wr(8'h00, 32'h7000);
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h1);
      wr(8'h40, 32'h8001);
      wr(8'h44, 32'h8000);
      cmd(32'h5);
      chk_rd(8'h40, 32'h0003);
      chk_rd(8'h44, 32'h0001);
      `CHK(carry_flag_o, 1'b1)
      wr(8'h00, 32'h4000);
      wr(8'h40, 32'h0001);
      wr(8'h44, 32'h0001);
      cmd(32'h5);
      chk_rd(8'h40, 32'h8000);
      chk_rd(8'h44, 32'h0000);
      wr(8'h00, 32'h3000);
      cmd(32'h5);
      chk_rd(8'h40, 32'h8000);
      `CHK(carry_flag_o, 1'b1)
      wr(8'h00, 32'hc000);
      cmd(32'h5);
      chk_rd(8'h40, 32'h0);
      chk_rd(8'h44, 32'h0);
      `CHK(carry_flag_o, 1'b0)
   endtask
   task t_cmp;
      for (int k = 0; k < 16; k++) begin
         wr(8'h80 + 8'(4 * k), (k == 0 || k == 3 || k == 15) ? 32'h1234 : 32'(k));
      end
      wr(8'h14, 32'h1234);
      cmd(32'h2);
      chk_rd(8'h18, 32'h8009);
      wr(8'h14, 32'h0005);
      cmd(32'h2);
      chk_rd(8'h18, 32'h0020);
   endtask
   task tally_and_finish;
      if (fails == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Watchdog sized well beyond the few hundred cycles the tests need
   initial begin
      #200000;
      fails++;
      tally_and_finish;
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_shift;
      t_cmp;
      tally_and_finish;
   end
endmodule
